/* File: src/slq_ctrl.sv */
/*
  Serial link quick-configuration presets and link control register 1, with sync request handling.
  Assumes the serial control port logic presents one-cycle read and write strobes on the core clock,
  and that the sync request pin is asynchronous to it.
*/
// Functional notes
// - Presets 81/82: one high-bandwidth channel
// - Preset 91: one low-bandwidth channel
// - Presets C1/C2/C4: two high-bandwidth channels
// - Presets D1/D2: two low-bandwidth channels
// - Presets E1/E2/E4: two mixed-bandwidth channels
// - Unlisted codes change nothing
// - Tail bits zero or LFSR filled
// - Test samples replace converter data
// - Lane sync selects allowed alignment characters
// - Alignment sequence off, on, repeat
// - Bit 1 stops alignment character insertion
// - Power-down resets and gates link
// - Send K28.5 only while requested or forced
// - Control register resets to zero
// - Quick-config register self clears
// - Sync request modes and polarity invert
`timescale 1ns/1ns
module slq_ctrl
  import slq_pkg::*;
#(
  parameter int unsigned TAIL_W = 4
) (
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  // Serial control port register access
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  input  wire logic [SLQ_ADDR_W-1:0] reg_addr_i,
  input  wire logic [SLQ_DATA_W-1:0] reg_wdata_i,
  output logic [SLQ_DATA_W-1:0]      reg_rdata_o,
  output logic                       reg_rvalid_o,
  // Receiver sync request pin, active low
  input  wire logic                  sync_request_input_n_i,
  // Link datapath
  input  wire logic                  sample_stb_i,
  output logic [TAIL_W-1:0]          tail_bits_o,
  output slq_link_t                  link_o,
  output logic                       cgs_send_o,
  output slq_cfg_t                   cfg_o
);

  slq_ctrl1_t  ctrl1_reg;
  slq_ctrl1_t  ctrl1_next;
  slq_ctrl2_t  ctrl2_reg;
  slq_cfg_t    cfg_reg;
  slq_cfg_t    cfg_next;
  logic        sync_meta_reg;
  logic        sync_pin_reg;
  logic        cgs_reg;
  logic        cgs_next;
  logic [7:0]  rdata_reg;
  logic        rvalid_reg;

  function automatic slq_preset_t preset_decode(input logic [7:0] code);
    slq_preset_t p;
    p.hit           = 1'b1;
    p.cfg.f72       = SLQ_FLD_F;
    p.cfg.f73       = SLQ_FLD_F;
    p.cfg.chan_mode = SLQ_CHMOD_RST;
    p.cfg.lanes     = SLQ_FLD5_RST;
    case (code)
      SLQ_QC_1H1: begin p.cfg.chan_mode = SLQ_CH_1H; p.cfg.lanes = SLQ_LANE_1; end
      SLQ_QC_1H2: begin p.cfg.chan_mode = SLQ_CH_1H; p.cfg.lanes = SLQ_LANE_2; end
      SLQ_QC_1L1: begin p.cfg.chan_mode = SLQ_CH_1L; p.cfg.lanes = SLQ_LANE_1; end
      SLQ_QC_2H1: begin p.cfg.chan_mode = SLQ_CH_2H; p.cfg.lanes = SLQ_LANE_1; end
      SLQ_QC_2H2: begin p.cfg.chan_mode = SLQ_CH_2H; p.cfg.lanes = SLQ_LANE_2; end
      SLQ_QC_2H4: begin p.cfg.chan_mode = SLQ_CH_2H; p.cfg.lanes = SLQ_LANE_4; end
      SLQ_QC_2L1: begin p.cfg.chan_mode = SLQ_CH_2L; p.cfg.lanes = SLQ_LANE_1; end
      SLQ_QC_2L2: begin p.cfg.chan_mode = SLQ_CH_2L; p.cfg.lanes = SLQ_LANE_2; end
      SLQ_QC_2M1: begin p.cfg.chan_mode = SLQ_CH_2M; p.cfg.lanes = SLQ_LANE_1; end
      SLQ_QC_2M2: begin p.cfg.chan_mode = SLQ_CH_2M; p.cfg.lanes = SLQ_LANE_2; end
      SLQ_QC_2M4: begin p.cfg.chan_mode = SLQ_CH_2M; p.cfg.lanes = SLQ_LANE_4; end
      default:    p.hit = 1'b0;
    endcase
    return p;
  endfunction

  // Address decode.
  wire         wr_qcfg  = reg_wr_i && (reg_addr_i == SLQ_ADDR_QCFG);
  wire         wr_ctrl1 = reg_wr_i && (reg_addr_i == SLQ_ADDR_CTRL1);
  wire         wr_ctrl2 = reg_wr_i && (reg_addr_i == SLQ_ADDR_CTRL2);
  wire         wr_chmod = reg_wr_i && (reg_addr_i == SLQ_ADDR_CHMOD);
  wire         wr_lanes = reg_wr_i && (reg_addr_i == SLQ_ADDR_LANES);
  wire         wr_f72   = reg_wr_i && (reg_addr_i == SLQ_ADDR_F72);
  wire         wr_f73   = reg_wr_i && (reg_addr_i == SLQ_ADDR_F73);
  slq_preset_t preset;
  assign preset = preset_decode(reg_wdata_i);
  wire         apply_preset = wr_qcfg && preset.hit;

  // A preset replaces all four fields on one edge, so the link never sees a half-applied mode.
  assign cfg_next.chan_mode = apply_preset ? preset.cfg.chan_mode :
                              wr_chmod     ? reg_wdata_i[3:0] : cfg_reg.chan_mode;
  assign cfg_next.lanes     = apply_preset ? preset.cfg.lanes :
                              wr_lanes     ? reg_wdata_i[4:0] : cfg_reg.lanes;
  assign cfg_next.f72       = apply_preset ? preset.cfg.f72 :
                              wr_f72       ? reg_wdata_i[4:0] : cfg_reg.f72;
  assign cfg_next.f73       = apply_preset ? preset.cfg.f73 :
                              wr_f73       ? reg_wdata_i[4:0] : cfg_reg.f73;

  // Bit 7 is unused and never stored.
  assign ctrl1_next = wr_ctrl1 ? slq_ctrl1_t'({1'b0, reg_wdata_i[6:0]}) : ctrl1_reg;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl1_reg <= slq_ctrl1_t'(SLQ_CTRL1_RST);
      ctrl2_reg <= slq_ctrl2_t'(SLQ_CTRL2_RST);
      cfg_reg   <= '{chan_mode: SLQ_CHMOD_RST, lanes: SLQ_FLD5_RST, f72: SLQ_FLD5_RST, f73: SLQ_FLD5_RST};
    end else begin
      ctrl1_reg <= ctrl1_next;
      cfg_reg   <= cfg_next;
      if (wr_ctrl2) begin
        ctrl2_reg <= slq_ctrl2_t'(reg_wdata_i[7:5]);
      end
    end
  end

  // The quick-config register holds no state; it reads back as zero at all times.
  wire [7:0] rd_mux =
    (reg_addr_i == SLQ_ADDR_QCFG)  ? SLQ_READ_ZERO :
    (reg_addr_i == SLQ_ADDR_CTRL1) ? ctrl1_reg :
    (reg_addr_i == SLQ_ADDR_CTRL2) ? {ctrl2_reg, 5'h00} :
    (reg_addr_i == SLQ_ADDR_CHMOD) ? {4'h0, cfg_reg.chan_mode} :
    (reg_addr_i == SLQ_ADDR_LANES) ? {3'h0, cfg_reg.lanes} :
    (reg_addr_i == SLQ_ADDR_F72)   ? {3'h0, cfg_reg.f72} :
    (reg_addr_i == SLQ_ADDR_F73)   ? {3'h0, cfg_reg.f73} : SLQ_READ_ZERO;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg  <= SLQ_READ_ZERO;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // Sync request pin: two flops, then polarity and mode.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_meta_reg <= 1'b1;
      sync_pin_reg  <= 1'b1;
      cgs_reg       <= 1'b0;
    end else begin
      sync_meta_reg <= sync_request_input_n_i;
      sync_pin_reg  <= sync_meta_reg;
      cgs_reg       <= cgs_next;
    end
  end

  wire sync_req = ~sync_pin_reg ^ ctrl2_reg.sync_invert;
  wire sync_eff = (ctrl2_reg.sync_mode == SLQ_SYNC_FORCE)  ? 1'b1 :
                  (ctrl2_reg.sync_mode == SLQ_SYNC_IGNORE) ? 1'b0 : sync_req;
  assign cgs_next = ~ctrl1_reg.power_down & sync_eff;

  // Link controls. Software keeps lane sync off while insertion is disabled; not enforced here.
  assign link_o.link_rst    = ctrl1_reg.power_down;
  assign link_o.link_clk_en = ~ctrl1_reg.power_down;
  assign link_o.test_sample = ctrl1_reg.test_sample;
  assign link_o.lane_sync   = ctrl1_reg.lane_sync;
  assign link_o.frame_align_char_insert_en     = ~ctrl1_reg.frame_align_char_insert_dis;
  assign link_o.k28_3_ok    = ctrl1_reg.lane_sync;
  assign link_o.ilas_en     = (ctrl1_reg.ilas_mode == SLQ_ILAS_ON);
  assign link_o.ilas_repeat = (ctrl1_reg.ilas_mode == SLQ_ILAS_REPEAT);
  assign cgs_send_o         = cgs_reg;
  assign cfg_o              = cfg_reg;
  assign reg_rdata_o        = rdata_reg;
  assign reg_rvalid_o       = rvalid_reg;

  slq_tail_fill #(
    .TAIL_W      (TAIL_W)
  ) u_tail_fill (
    .core_clk_i   (core_clk_i),
    .rst_i        (rst_i),
    .link_rst_i   (ctrl1_reg.power_down),
    .fill_en_i    (ctrl1_reg.tail_fill),
    .sample_stb_i (sample_stb_i),
    .tail_bits_o  (tail_bits_o)
  );

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  AST_PRESET_82: assert property (wr_qcfg && reg_wdata_i == SLQ_QC_1H2 |=>
    cfg_o.chan_mode == SLQ_CH_1H && cfg_o.lanes == SLQ_LANE_2 && cfg_o.f72 == SLQ_FLD_F && cfg_o.f73 == SLQ_FLD_F)
    else $error("Preset 82 fields wrong.");
  AST_PRESET_91: assert property (wr_qcfg && reg_wdata_i == SLQ_QC_1L1 |=>
    cfg_o.chan_mode == SLQ_CH_1L && cfg_o.lanes == SLQ_LANE_1)
    else $error("Preset 91 fields wrong.");
  AST_PRESET_C4: assert property (wr_qcfg && reg_wdata_i == SLQ_QC_2H4 |=>
    cfg_o.chan_mode == SLQ_CH_2H && cfg_o.lanes == SLQ_LANE_4 && cfg_o.f73 == SLQ_FLD_F)
    else $error("Preset C4 fields wrong.");
  AST_PRESET_D2: assert property (wr_qcfg && reg_wdata_i == SLQ_QC_2L2 |=>
    cfg_o.chan_mode == SLQ_CH_2L && cfg_o.lanes == SLQ_LANE_2)
    else $error("Preset D2 fields wrong.");
  AST_PRESET_E1: assert property (wr_qcfg && reg_wdata_i == SLQ_QC_2M1 |=>
    cfg_o.chan_mode == SLQ_CH_2M && cfg_o.lanes == SLQ_LANE_1 && cfg_o.f72 == SLQ_FLD_F)
    else $error("Preset E1 fields wrong.");
  AST_UNLISTED: assert property (wr_qcfg && !preset.hit && !wr_ctrl1 |=> $stable(cfg_o) && $stable(ctrl1_reg))
    else $error("Unlisted code changed a register.");
  AST_TEST_SAMPLE: assert property (wr_ctrl1 |=> link_o.test_sample == $past(reg_wdata_i[5]))
    else $error("Test sample enable not following bit 5.");
  AST_ILAS: assert property (wr_ctrl1 && reg_wdata_i[3:2] == SLQ_ILAS_REPEAT |=> link_o.ilas_repeat && !link_o.ilas_en)
    else $error("Alignment sequence mode decode wrong.");
  AST_FRAME_ALIGN_CHAR_INSERT: assert property (wr_ctrl1 |=> link_o.frame_align_char_insert_en == !$past(reg_wdata_i[1]))
    else $error("Insertion enable inverted.");
  AST_PD: assert property (wr_ctrl1 && reg_wdata_i[0] |=> link_o.link_rst && !link_o.link_clk_en ##1 !cgs_send_o)
    else $error("Power-down did not reset link or stop sync.");
  AST_CGS: assert property (!ctrl1_reg.power_down && ctrl2_reg.sync_mode == SLQ_SYNC_NORMAL && !ctrl2_reg.sync_invert
    && $stable(ctrl1_reg) && $stable(ctrl2_reg) && !sync_pin_reg |=> cgs_send_o)
    else $error("Sync characters not sent on request.");
  AST_FORCE: assert property (ctrl2_reg.sync_mode == SLQ_SYNC_FORCE && !ctrl1_reg.power_down |=>
    cgs_send_o || $past(wr_ctrl1) || $past(wr_ctrl2))
    else $error("Forced sync mode not sending.");
  AST_QCFG_READ: assert property (reg_rd_i && reg_addr_i == SLQ_ADDR_QCFG |=> reg_rvalid_o && reg_rdata_o == SLQ_READ_ZERO)
    else $error("Quick-config register did not read zero.");
  AST_BIT7: assert property (reg_rd_i && reg_addr_i == SLQ_ADDR_CTRL1 |=> !reg_rdata_o[7])
    else $error("Unused control bit read as one.");

  COV_PRESET: cover property (apply_preset ##1 reg_rd_i && reg_addr_i == SLQ_ADDR_LANES);
  COV_OVERRIDE: cover property (apply_preset ##[1:4] wr_lanes);
  COV_CGS_END: cover property (cgs_send_o ##1 !cgs_send_o);
  COV_LANESYNC: cover property (link_o.lane_sync && link_o.frame_align_char_insert_en && link_o.ilas_en);

endmodule // slq_ctrl

/* File: pkg/slq_pkg.sv */
/*
  Shared constants and types for the serial link quick-configuration and link control block.
  Assumes one core clock domain and a register port that presents byte-wide accesses.
*/
package slq_pkg;

  localparam int unsigned SLQ_ADDR_W = 8;
  localparam int unsigned SLQ_DATA_W = 8;

  // Register offsets.
  localparam logic [7:0] SLQ_ADDR_QCFG  = 8'h5e;
  localparam logic [7:0] SLQ_ADDR_CTRL1 = 8'h5f;
  localparam logic [7:0] SLQ_ADDR_CTRL2 = 8'h60;
  localparam logic [7:0] SLQ_ADDR_CHMOD = 8'h63;
  localparam logic [7:0] SLQ_ADDR_LANES = 8'h6e;
  localparam logic [7:0] SLQ_ADDR_F72   = 8'h72;
  localparam logic [7:0] SLQ_ADDR_F73   = 8'h73;

  // Reset values.
  localparam logic [7:0] SLQ_CTRL1_RST = 8'h00;
  localparam logic [2:0] SLQ_CTRL2_RST = 3'h0;
  localparam logic [3:0] SLQ_CHMOD_RST = 4'h0;
  localparam logic [4:0] SLQ_FLD5_RST  = 5'h00;
  localparam logic [7:0] SLQ_READ_ZERO = 8'h00;

  // Alignment sequence modes.
  localparam logic [1:0] SLQ_ILAS_OFF    = 2'b00;
  localparam logic [1:0] SLQ_ILAS_ON     = 2'b01;
  localparam logic [1:0] SLQ_ILAS_REPEAT = 2'b11;

  // Synchronization request modes.
  localparam logic [1:0] SLQ_SYNC_NORMAL = 2'b00;
  localparam logic [1:0] SLQ_SYNC_FORCE  = 2'b10;
  localparam logic [1:0] SLQ_SYNC_IGNORE = 2'b11;

  // Preset codes.
  localparam logic [7:0] SLQ_QC_1H1 = 8'h81;
  localparam logic [7:0] SLQ_QC_1H2 = 8'h82;
  localparam logic [7:0] SLQ_QC_1L1 = 8'h91;
  localparam logic [7:0] SLQ_QC_2H1 = 8'hc1;
  localparam logic [7:0] SLQ_QC_2H2 = 8'hc2;
  localparam logic [7:0] SLQ_QC_2H4 = 8'hc4;
  localparam logic [7:0] SLQ_QC_2L1 = 8'hd1;
  localparam logic [7:0] SLQ_QC_2L2 = 8'hd2;
  localparam logic [7:0] SLQ_QC_2M1 = 8'he1;
  localparam logic [7:0] SLQ_QC_2M2 = 8'he2;
  localparam logic [7:0] SLQ_QC_2M4 = 8'he4;

  // Preset field values.
  localparam logic [3:0] SLQ_CH_1H  = 4'h8;
  localparam logic [3:0] SLQ_CH_1L  = 4'h9;
  localparam logic [3:0] SLQ_CH_2H  = 4'hc;
  localparam logic [3:0] SLQ_CH_2L  = 4'hd;
  localparam logic [3:0] SLQ_CH_2M  = 4'he;
  localparam logic [4:0] SLQ_LANE_1 = 5'h00;
  localparam logic [4:0] SLQ_LANE_2 = 5'h01;
  localparam logic [4:0] SLQ_LANE_4 = 5'h03;
  localparam logic [4:0] SLQ_FLD_F  = 5'h0f;

  // Tail fill generator.
  localparam int unsigned SLQ_LFSR_W   = 31;
  localparam int unsigned SLQ_LFSR_TAP = 28;
  localparam logic [30:0] SLQ_LFSR_SEED = 31'h7fff_ffff;

  typedef struct packed {
    logic       unused;
    logic       tail_fill;
    logic       test_sample;
    logic       lane_sync;
    logic [1:0] ilas_mode;
    logic       frame_align_char_insert_dis;
    logic       power_down;
  } slq_ctrl1_t;

  typedef struct packed {
    logic [1:0] sync_mode;
    logic       sync_invert;
  } slq_ctrl2_t;

  typedef struct packed {
    logic [3:0] chan_mode;
    logic [4:0] lanes;
    logic [4:0] f72;
    logic [4:0] f73;
  } slq_cfg_t;

  typedef struct packed {
    logic     hit;
    slq_cfg_t cfg;
  } slq_preset_t;

  typedef struct packed {
    logic       link_rst;
    logic       link_clk_en;
    logic       test_sample;
    logic       lane_sync;
    logic       frame_align_char_insert_en;
    logic       k28_3_ok;
    logic       ilas_en;
    logic       ilas_repeat;
  } slq_link_t;

endpackage

/* File: src/slq_tail_fill.sv */
/*
  Tail-bit filler: zero padding or bits from a 31-bit LFSR, several bits per sample.
  Assumes sample_stb_i comes from logic on the core clock and that the link reset clears it.
*/
`timescale 1ns/1ns
module slq_tail_fill
  import slq_pkg::*;
#(
  parameter int unsigned TAIL_W = 4
) (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  // Control
  input  wire logic              link_rst_i,
  input  wire logic              fill_en_i,
  input  wire logic              sample_stb_i,
  // Fill bits
  output logic [TAIL_W-1:0]      tail_bits_o
);

  logic [SLQ_LFSR_W-1:0] lfsr_reg;
  logic [SLQ_LFSR_W-1:0] chain [TAIL_W+1];
  logic [TAIL_W-1:0]     bits_next;
  logic [TAIL_W-1:0]     tail_reg;

  assign chain[0] = lfsr_reg;

  // One LFSR step per fill bit, so a sample consumes TAIL_W steps in one cycle.
  genvar k;
  generate
    for (k = 0; k < TAIL_W; k++) begin : g_step
      assign bits_next[TAIL_W-1-k] = chain[k][SLQ_LFSR_W-1];
      assign chain[k+1] = {chain[k][SLQ_LFSR_W-2:0],
                           chain[k][SLQ_LFSR_W-1] ^ chain[k][SLQ_LFSR_TAP-1]};
    end
  endgenerate

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lfsr_reg <= SLQ_LFSR_SEED;
      tail_reg <= '0;
    end else if (link_rst_i) begin
      lfsr_reg <= SLQ_LFSR_SEED;
      tail_reg <= '0;
    end else if (sample_stb_i) begin
      lfsr_reg <= chain[TAIL_W];
      tail_reg <= fill_en_i ? bits_next : '0;
    end
  end

  assign tail_bits_o = tail_reg;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  AST_TAIL_ZERO: assert property (sample_stb_i && !fill_en_i |=> tail_bits_o == '0)
    else $error("Tail bits not zero with fill disabled.");
  AST_LFSR_ALIVE: assert property (lfsr_reg != '0)
    else $error("Fill LFSR locked at zero.");
  COV_FILL: cover property (sample_stb_i && fill_en_i ##1 tail_bits_o != '0);

endmodule // slq_tail_fill

/* File: test/slq_rx_model.sv */
/*
  Behavioural model of the link receiver that drives the sync request pin.
  Assumes the bench commands when a request is wanted and how many cycles the receiver waits first.
*/
`timescale 1ns/1ns
module slq_rx_model (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Bench command
  input  wire logic       req_i,
  input  wire logic [3:0] dly_i,
  // Pin towards the device, active low
  output logic            sync_request_input_n_o
);
  logic [3:0] wait_reg;

  // The receiver may be slow to ask, so a request only lands after dly_i cycles.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_reg               <= 4'h0;
      sync_request_input_n_o <= 1'b1;
    end else if (!req_i) begin
      wait_reg               <= 4'h0;
      sync_request_input_n_o <= 1'b1;
    end else if (wait_reg == dly_i) begin
      sync_request_input_n_o <= 1'b0;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule // slq_rx_model

/* File: test/test_slq_ctrl.sv */
/*
  Self-checking bench for the quick-configuration and link control block.
  Assumes the receiver model drives the sync pin and the bench owns the register port.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module test_slq_ctrl
  import slq_pkg::*;
;
  localparam int unsigned TW = 4;
  logic            core_clk_i  = 1'b0;
  logic            rst_i       = 1'b1;
  logic            reg_wr_i    = 1'b0;
  logic            reg_rd_i    = 1'b0;
  logic [7:0]      reg_addr_i  = 8'h00;
  logic [7:0]      reg_wdata_i = 8'h00;
  logic            sample_stb_i = 1'b0;
  logic            req         = 1'b0;
  logic [3:0]      dly         = 4'h0;
  logic            sync_n;
  logic [7:0]      reg_rdata_o;
  logic            reg_rvalid_o;
  logic [TW-1:0]   tail_bits_o;
  slq_link_t       link_o;
  logic            cgs_send_o;
  slq_cfg_t        cfg_o;
  int              err_count = 0;
  int              cmp_count = 0;
  int              cycles    = 0;

  always #2 core_clk_i = ~core_clk_i;

  slq_ctrl #(.TAIL_W(TW)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .sync_request_input_n_i(sync_n), .sample_stb_i(sample_stb_i), .tail_bits_o(tail_bits_o),
    .link_o(link_o), .cgs_send_o(cgs_send_o), .cfg_o(cfg_o));
  slq_rx_model rx (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req), .dly_i(dly),
    .sync_request_input_n_o(sync_n));

  task automatic print_verdict();
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK(reg_rvalid_o, 1'b1)
    `CHK(reg_rdata_o, e)
  endtask

  task automatic strobe(output logic [TW-1:0] b);
    @(posedge core_clk_i);
    sample_stb_i <= 1'b1;
    @(posedge core_clk_i);
    sample_stb_i <= 1'b0;
    #1;
    b = tail_bits_o;
  endtask

  // Waits a fixed settle time after a mode change, since the pin path is three flops deep.
  task automatic settle_cgs(input logic e);
    repeat (4) @(posedge core_clk_i);
    #1;
    `CHK(cgs_send_o, e)
  endtask

  task automatic t_reset();
    `CHK(link_o, 8'b0100_1000)
    `CHK(cfg_o, 19'h0_0000)
    chk_rd(8'h5f, 8'h00);
    chk_rd(8'h5e, 8'h00);
    $display("done: reset");
  endtask

  task automatic t_ctrl();
    logic [7:0] v[9] = '{8'h00, 8'h02, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h40, 8'hfd};
    logic [7:0] e;
    foreach (v[i]) begin
      wr(8'h5f, 8'h01);
      wr(8'h5f, v[i] | 8'h01);
      wr(8'h5f, v[i]);
      e = {v[i][0], ~v[i][0], v[i][5], v[i][4], ~v[i][1], v[i][4], v[i][3:2] == 2'b01, v[i][3:2] == 2'b11};
      `CHK(link_o, e)
      chk_rd(8'h5f, v[i] & 8'h7f);
    end
    $display("done: control");
  endtask

  task automatic t_preset();
    logic [15:0] p[11] = '{16'h8180, 16'h8281, 16'h9190, 16'hc1c0, 16'hc2c1, 16'hc4c3,
                          16'hd1d0, 16'hd2d1, 16'he1e0, 16'he2e1, 16'he4e3};
    logic [7:0]  u[5] = '{8'h00, 8'h01, 8'h18, 8'h83, 8'hff};
    wr(8'h5f, 8'h01);
    foreach (p[i]) begin
      wr(8'h5e, p[i][15:8]);
      `CHK(cfg_o, {p[i][7:4], 1'b0, p[i][3:0], 5'h0f, 5'h0f})
      chk_rd(8'h5e, 8'h00);
    end
    chk_rd(8'h72, 8'h0f);
    foreach (u[i]) begin
      wr(8'h5e, u[i]);
      `CHK(cfg_o, {4'he, 5'h03, 5'h0f, 5'h0f})
    end
    wr(8'h6e, 8'h05);
    chk_rd(8'h6e, 8'h05);
    wr(8'h63, 8'hf5);
    wr(8'h72, 8'hff);
    wr(8'h73, 8'h0a);
    `CHK(cfg_o, {4'h5, 5'h05, 5'h1f, 5'h0a})
    chk_rd(8'h63, 8'h05);
    chk_rd(8'h73, 8'h0a);
    wr(8'h5e, 8'hc2);
    `CHK(cfg_o, {4'hc, 5'h01, 5'h0f, 5'h0f})
    chk_rd(8'h10, 8'h00);
    wr(8'h5f, 8'h00);
    $display("done: presets");
  endtask

  task automatic t_sync();
    dly = 4'h3;
    req = 1'b1;
    for (int i = 0; i < 20 && sync_n !== 1'b0; i++) @(negedge core_clk_i);
    repeat (2) @(posedge core_clk_i);
    #1;
    `CHK(cgs_send_o, 1'b0)
    @(posedge core_clk_i);
    #1;
    `CHK(cgs_send_o, 1'b1)
    req = 1'b0;
    // From here on the receiver asks at once, so four edges cover the pin path.
    dly = 4'h0;
    settle_cgs(1'b0);
    req = 1'b1;
    settle_cgs(1'b1);
    wr(8'h5f, 8'h01);
    @(posedge core_clk_i);
    #1;
    `CHK(cgs_send_o, 1'b0)
    wr(8'h60, 8'hc0);
    wr(8'h5f, 8'h00);
    settle_cgs(1'b0);
    req = 1'b0;
    wr(8'h5f, 8'h01);
    wr(8'h60, 8'h80);
    wr(8'h5f, 8'h00);
    settle_cgs(1'b1);
    wr(8'h5f, 8'h01);
    wr(8'h60, 8'h3f);
    wr(8'h5f, 8'h00);
    settle_cgs(1'b1);
    req = 1'b1;
    repeat (4) @(posedge core_clk_i);
    settle_cgs(1'b0);
    req = 1'b0;
    chk_rd(8'h60, 8'h20);
    $display("done: sync");
  endtask

  // Reference generator for x^31 + x^28 + 1, most significant fill bit first.
  function automatic logic [TW-1:0] ref_fill(inout logic [30:0] s);
    logic [TW-1:0] r;
    r = '0;
    for (int j = TW - 1; j >= 0; j--) begin
      r[j] = s[30];
      s    = {s[29:0], s[30] ^ s[27]};
    end
    return r;
  endfunction

  task automatic t_tail();
    logic [TW-1:0] b;
    logic [TW-1:0] first;
    logic [TW-1:0] acc;
    logic [30:0]   lf;
    logic [TW-1:0] eb;
    int            nch;
    wr(8'h5f, 8'h00);
    for (int i = 0; i < 3; i++) begin
      strobe(b);
      `CHK(b, '0)
    end
    wr(8'h5f, 8'h01);
    wr(8'h5f, 8'h41);
    wr(8'h5f, 8'h40);
    strobe(first);
    lf = SLQ_LFSR_SEED;
    eb = ref_fill(lf);
    `CHK(first, eb)
    acc = first;
    nch = 0;
    for (int i = 0; i < 8; i++) begin
      strobe(b);
      eb = ref_fill(lf);
      `CHK(b, eb)
      nch += (b !== acc) ? 1 : 0;
      acc = b;
    end
    `CHK(nch > 0, 1'b1)
    wr(8'h5f, 8'h41);
    @(posedge core_clk_i);
    #1;
    `CHK(tail_bits_o, '0)
    strobe(b);
    `CHK(b, '0)
    wr(8'h5f, 8'h40);
    strobe(b);
    `CHK(b, first)
    $display("done: tail fill");
  endtask

  initial begin
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    #1;
    t_reset();
    t_ctrl();
    t_preset();
    t_sync();
    t_tail();
    print_verdict();
  end
endmodule // test_slq_ctrl
